// ### shared/serial_attenuator_control_map.svh
// Constant map of the serial attenuator control: frame layout, codes, timing
`ifndef SERIAL_ATTENUATOR_CONTROL_MAP_SVH
`define SERIAL_ATTENUATOR_CONTROL_MAP_SVH

// ==========================================================================
// Frame layout
`define SAC_FRAME_BITS      16
`define SAC_FIELD_BITS      8
`define SAC_ADDR_MSB        15
`define SAC_ADDR_LSB        8
`define SAC_CODE_MSB        7
`define SAC_CODE_LSB        0

// ==========================================================================
// Channel select values
`define SAC_ADDR_CH_A       8'h00
`define SAC_ADDR_CH_B       8'h01
`define SAC_ADDR_CH_C       8'h02

// ==========================================================================
// Attenuation code ranges
`define SAC_FINE_LAST       8'h5f
`define SAC_COARSE_FIRST    8'h60
`define SAC_COARSE_LAST     8'h7e
`define SAC_MUTE_FIRST      8'h7f
// 48 dB expressed in half-dB units
`define SAC_COARSE_BASE     8'h60

// ==========================================================================
// Reset values
`define SAC_RESET_MUTE      1'b1
`define SAC_RESET_ATTEN     8'h00
`define SAC_RESET_SHIFT     16'h0000
// Idle pin levels, bit 0 clock, bit 1 load/shift enable, bit 2 data
`define SAC_PIN_IDLE        3'h2

// ==========================================================================
// Timing
`define SAC_CLK_PERIOD_NS   20
`define SAC_SETUP_NS        150
`define SAC_SETUP_CYCLES    ((`SAC_SETUP_NS + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS)

`endif

// ### shared/serial_attenuator_control_pkg.sv
// Types shared by the serial attenuator control modules
package serial_attenuator_control_pkg;

    // ======================================================================
    // Field and frame types
    typedef logic [7:0] byte_t;

    typedef struct packed {
        byte_t address;
        byte_t code;
    } frame_s;

    // ======================================================================
    // Link receiver states
    typedef enum logic [1:0] {
        LINK_IDLE,
        LINK_SHIFT,
        LINK_LATCH,
        LINK_DECODE
    } link_state_e;

endpackage

// ### shared/tap_select_if.sv
// Interface between the link receiver and the attenuation code decoder
`timescale 1ns/100ps

interface tap_select_if;
    logic [7:0] code;
    logic [7:0] atten_half_db;
    logic       mute;

    // Receiver hands over the latched code and takes the decoded setting
    modport receiver (
        output code,
        input  atten_half_db,
        input  mute
    );

    // Decoder turns a code into a tap setting
    modport decoder (
        input  code,
        output atten_half_db,
        output mute
    );
endinterface

// ### hw/attenuation_decoder.sv
// Attenuation code decoder: code to half-dB tap setting or mute
`timescale 1ns/100ps
`include "serial_attenuator_control_map.svh"

module attenuation_decoder (
    tap_select_if.decoder tap
);

    // ======================================================================
    // Code ranges
    logic [7:0] coarse_step;

    // Steps above the first coarse code, each worth one dB or two half-dB
    assign coarse_step = tap.code - `SAC_COARSE_FIRST;

    // Pure decode; the receiver registers the result per channel
    always_comb begin
        if (tap.code <= `SAC_FINE_LAST) begin
            tap.atten_half_db = tap.code;
            tap.mute          = 1'b0;
        end else if (tap.code <= `SAC_COARSE_LAST) begin
            tap.atten_half_db = `SAC_COARSE_BASE + {coarse_step[6:0], 1'b0};
            tap.mute          = 1'b0;
        end else begin
            // Whole upper range mutes, no matter the level before
            tap.atten_half_db = `SAC_RESET_ATTEN;
            tap.mute          = 1'b1;
        end
    end

endmodule // attenuation_decoder

// ### hw/serial_attenuator_control.sv
// Serial attenuator control: three-wire link receiver and per-channel settings
`timescale 1ns/100ps
`include "serial_attenuator_control_map.svh"

// How it works
// - Shift data in on rising serial clock
// - Shift only while load/shift enable is low
// - Old register contents leave on chain output
// - Frame is address byte then code byte
// - MSB first, address byte before code
// - Address n selects channel n, for n below CHANNELS (two by default)
// - Only recognised address updates its channel
// - Low codes give half-dB steps to 47.5
// - Middle codes give 48 to 78 dB
// - Codes from 0x7f upward mute channel
// - Mute applies directly from any level
// - Every channel muted at power-up
// - Enable rise latches then decodes frame
module serial_attenuator_control
    import serial_attenuator_control_pkg::*;
#(
    parameter int CHANNELS = 2,
    parameter int COUNT_W  = 8
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_sys_rst,
    input  wire logic                    i_serial_clk,
    input  wire logic                    i_load_shift_n,
    input  wire logic                    i_serial_data,
    output logic                         o_chain_data,
    output logic [CHANNELS-1:0]          o_mute,
    output logic [CHANNELS*8-1:0]        o_atten_half_db,
    output logic [CHANNELS-1:0]          o_update,
    output logic [7:0]                   o_frame_addr,
    output logic [7:0]                   o_frame_code,
    output logic [COUNT_W-1:0]           o_bit_count,
    output logic                         o_short_frame,
    output logic                         o_addr_miss,
    output logic                         o_setup_violation,
    output logic                         o_busy
);

    // ======================================================================
    // Constants
    localparam int         FRAME_BITS   = `SAC_FRAME_BITS;
    localparam int         SETUP_CYCLES = `SAC_SETUP_CYCLES;
    localparam logic [3:0] SETUP_LIMIT  = 4'(SETUP_CYCLES);
    localparam logic [COUNT_W-1:0] COUNT_MAX   = '1;
    localparam logic [COUNT_W-1:0] FRAME_COUNT = COUNT_W'(FRAME_BITS);

    // Does a channel select byte name channel number ch
    function automatic logic channel_hit(input byte_t addr, input int ch);
        return addr == (`SAC_ADDR_CH_A + 8'(ch));
    endfunction

    // ======================================================================
    // Pin synchronisers and glitch filter
    // Bit 0 serial clock, bit 1 load/shift enable, bit 2 serial data
    logic [2:0] sync1_q;
    logic [2:0] sync1_d;
    logic [2:0] sync2_q;
    logic [2:0] sync2_d;
    logic [2:0] sync3_q;
    logic [2:0] sync3_d;
    logic [2:0] filt_q;
    logic [2:0] filt_d;
    logic [2:0] prev_q;
    logic [2:0] prev_d;
    logic [2:0] agree;

    // A level counts only once stages two and three agree
    always_comb begin
        sync1_d = {i_serial_data, i_load_shift_n, i_serial_clk};
        sync2_d = sync1_q;
        sync3_d = sync2_q;
        agree   = ~(sync2_q ^ sync3_q);
        filt_d  = (agree & sync2_q) | (~agree & filt_q);
        prev_d  = filt_q;
    end

    // Idle levels at reset so no false edge shows on release
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            sync1_q <= `SAC_PIN_IDLE;
            sync2_q <= `SAC_PIN_IDLE;
            sync3_q <= `SAC_PIN_IDLE;
            filt_q  <= `SAC_PIN_IDLE;
            prev_q  <= `SAC_PIN_IDLE;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            sync3_q <= sync3_d;
            filt_q  <= filt_d;
            prev_q  <= prev_d;
        end
    end

    // ======================================================================
    // Edge detection on the filtered pins
    logic clk_rise;
    logic en_low;
    logic en_rise;
    logic data_bit;

    // All three pins share one pipeline, so data lines up with its clock
    assign clk_rise = filt_q[0] & ~prev_q[0];
    assign en_low   = ~filt_q[1];
    assign en_rise  = filt_q[1] & ~prev_q[1];
    assign data_bit = filt_q[2];

    // ======================================================================
    // Link receiver state machine
    link_state_e               state_q;
    link_state_e               state_d;
    logic [FRAME_BITS-1:0]     shift_q;
    logic [FRAME_BITS-1:0]     shift_d;
    logic [COUNT_W-1:0]        bit_cnt_q;
    logic [COUNT_W-1:0]        bit_cnt_d;
    logic [3:0]                setup_cnt_q;
    logic [3:0]                setup_cnt_d;
    logic                      setup_viol_q;
    logic                      setup_viol_d;
    logic                      short_q;
    logic                      short_d;
    frame_s                    frame_q;
    frame_s                    frame_d;

    // Next state, shift register and frame capture
    always_comb begin
        state_d      = state_q;
        shift_d      = shift_q;
        bit_cnt_d    = bit_cnt_q;
        setup_cnt_d  = setup_cnt_q;
        setup_viol_d = setup_viol_q;
        short_d      = short_q;
        frame_d      = frame_q;
        unique case (state_q)
            LINK_IDLE: begin
                // Clock edges with enable high are simply dropped
                if (en_low) begin
                    state_d      = LINK_SHIFT;
                    bit_cnt_d    = '0;
                    setup_cnt_d  = 4'h1;
                    setup_viol_d = 1'b0;
                end
            end
            LINK_SHIFT: begin
                if (setup_cnt_q != SETUP_LIMIT) begin
                    setup_cnt_d = setup_cnt_q + 4'h1;
                end
                if (clk_rise && en_low) begin
                    // MSB arrives first and ends up at the top
                    shift_d = {shift_q[FRAME_BITS-2:0], data_bit};
                    if (bit_cnt_q != COUNT_MAX) begin
                        bit_cnt_d = bit_cnt_q + 1'b1;
                    end
                    // First clock too soon after enable fell
                    if (bit_cnt_q == '0 && setup_cnt_q < SETUP_LIMIT) begin
                        setup_viol_d = 1'b1;
                    end
                end
                // Relies on the host raising enable only once all bits are in
                if (en_rise) begin
                    state_d = LINK_LATCH;
                end
            end
            LINK_LATCH: begin
                // Newest sixteen bits; longer chains leave older bits behind
                frame_d.address = shift_q[`SAC_ADDR_MSB:`SAC_ADDR_LSB];
                frame_d.code    = shift_q[`SAC_CODE_MSB:`SAC_CODE_LSB];
                short_d         = bit_cnt_q < FRAME_COUNT;
                state_d         = LINK_DECODE;
            end
            LINK_DECODE: begin
                state_d = LINK_IDLE;
            end
        endcase
    end

    // Receiver registers
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_q      <= LINK_IDLE;
            shift_q      <= `SAC_RESET_SHIFT;
            bit_cnt_q    <= '0;
            setup_cnt_q  <= 4'h0;
            setup_viol_q <= 1'b0;
            short_q      <= 1'b0;
            frame_q      <= '0;
        end else begin
            state_q      <= state_d;
            shift_q      <= shift_d;
            bit_cnt_q    <= bit_cnt_d;
            setup_cnt_q  <= setup_cnt_d;
            setup_viol_q <= setup_viol_d;
            short_q      <= short_d;
            frame_q      <= frame_d;
        end
    end

    // ======================================================================
    // Attenuation decode
    tap_select_if tap ();

    // Decoder sees the latched code, never the moving shift register
    assign tap.code = frame_q.code;

    attenuation_decoder u_decoder (
        .tap (tap)
    );

    // ======================================================================
    // Channel settings
    logic [CHANNELS-1:0]       mute_q;
    logic [CHANNELS-1:0]       mute_d;
    logic [CHANNELS-1:0][7:0]  atten_q;
    logic [CHANNELS-1:0][7:0]  atten_d;
    logic [CHANNELS-1:0]       update_q;
    logic [CHANNELS-1:0]       update_d;
    logic                      miss_q;
    logic                      miss_d;

    // Write only the addressed channel; the rest keep their settings
    always_comb begin
        mute_d   = mute_q;
        atten_d  = atten_q;
        update_d = '0;
        miss_d   = miss_q;
        if (state_q == LINK_DECODE) begin
            miss_d = 1'b1;
            for (int ch = 0; ch < CHANNELS; ch++) begin
                if (channel_hit(frame_q.address, ch)) begin
                    // Mute or level lands in one step
                    mute_d[ch]   = tap.mute;
                    atten_d[ch]  = tap.atten_half_db;
                    update_d[ch] = 1'b1;
                    miss_d       = 1'b0;
                end
            end
        end
    end

    // Power-up state is mute on every channel
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            mute_q   <= {CHANNELS{`SAC_RESET_MUTE}};
            atten_q  <= {CHANNELS{`SAC_RESET_ATTEN}};
            update_q <= '0;
            miss_q   <= 1'b0;
        end else begin
            mute_q   <= mute_d;
            atten_q  <= atten_d;
            update_q <= update_d;
            miss_q   <= miss_d;
        end
    end

    // ======================================================================
    // Outputs
    // Top bit is what a downstream device samples on its next clock
    assign o_chain_data      = shift_q[FRAME_BITS-1];
    assign o_mute            = mute_q;
    assign o_atten_half_db   = atten_q;
    assign o_update          = update_q;
    assign o_frame_addr      = frame_q.address;
    assign o_frame_code      = frame_q.code;
    assign o_bit_count       = bit_cnt_q;
    assign o_short_frame     = short_q;
    assign o_addr_miss       = miss_q;
    assign o_setup_violation = setup_viol_q;
    assign o_busy            = state_q != LINK_IDLE;

endmodule // serial_attenuator_control

// ### tb/host_link_model.sv
// Host side of the three-wire link: frames, idle clocks, chain capture
`timescale 1ns/100ps

module host_link_model (
    input  wire logic i_clk,
    input  wire logic i_chain_data,
    output logic      o_serial_clk,
    output logic      o_load_shift_n,
    output logic      o_serial_data
);
    // ==========================================================================
    // Idle levels: clock low and still, enable high
    initial begin
        o_serial_clk   = 1'b0;
        o_load_shift_n = 1'b1;
        o_serial_data  = 1'b0;
    end

    // Send n bits MSB first, farthest frame first; lead cycles before data
    task automatic send(input logic [31:0] bits, input int n, input int lead,
                        output logic [31:0] seen);
        seen = '0;
        @(posedge i_clk);
        o_load_shift_n <= 1'b0;
        repeat (lead) @(posedge i_clk);
        for (int k = n - 1; k >= 0; k--) begin
            o_serial_data <= bits[k];
            repeat (4) @(posedge i_clk);
            seen[k] = i_chain_data; // Settled since the last rise
            o_serial_clk <= 1'b1;
            repeat (4) @(posedge i_clk);
            o_serial_clk <= 1'b0;
        end
        repeat (4) @(posedge i_clk);
        o_serial_data  <= ~o_serial_data; // Released line shows no stale bit
        o_load_shift_n <= 1'b1;
        repeat (16) @(posedge i_clk);
    endtask

    // Clock edges with the enable held high
    task automatic idle_pulses(input int n);
        repeat (n) begin
            @(posedge i_clk);
            o_serial_clk <= 1'b1;
            repeat (4) @(posedge i_clk);
            o_serial_clk <= 1'b0;
            repeat (3) @(posedge i_clk);
        end
        repeat (8) @(posedge i_clk);
    endtask
endmodule // host_link_model

// ### tb/serial_attenuator_control_chk.sv
// Port-level assertions for the serial attenuator control
`timescale 1ns/100ps

module serial_attenuator_control_chk #(
    parameter int CHANNELS = 2,
    parameter int COUNT_W  = 8
) (
    input wire logic                  i_clk,
    input wire logic                  i_sys_rst,
    input wire logic                  i_serial_clk,
    input wire logic                  i_load_shift_n,
    input wire logic                  i_serial_data,
    input wire logic                  o_chain_data,
    input wire logic [CHANNELS-1:0]   o_mute,
    input wire logic [CHANNELS*8-1:0] o_atten_half_db,
    input wire logic [CHANNELS-1:0]   o_update,
    input wire logic [7:0]            o_frame_addr,
    input wire logic [7:0]            o_frame_code,
    input wire logic [COUNT_W-1:0]    o_bit_count,
    input wire logic                  o_short_frame,
    input wire logic                  o_addr_miss,
    input wire logic                  o_setup_violation,
    input wire logic                  o_busy
);
    // ==========================================================================
    // Assertions, all in the system clock domain
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    a_power_mute: assert property ($fell(i_sys_rst) |-> &o_mute && o_atten_half_db == '0)
        else $error("channels not muted after reset");
    a_decode_fine: assert property (o_update[0] && o_frame_code <= 8'h5f
        |-> !o_mute[0] && o_atten_half_db[7:0] == o_frame_code) else $error("fine step wrong");
    a_decode_coarse: assert property (o_update[0] && o_frame_code inside {[8'h60:8'h7e]}
        |-> !o_mute[0] && o_atten_half_db[7:0] == {o_frame_code[6:0], 1'b0} - 8'h60)
        else $error("coarse step wrong");
    a_decode_mute: assert property (o_update[0] && o_frame_code >= 8'h7f |-> o_mute[0])
        else $error("mute code ignored");
    a_update_addr: assert property (o_update != '0
        |-> o_update == (CHANNELS'(1) << o_frame_addr)) else $error("wrong channel updated");
    a_hold_setting: assert property (((o_mute ^ $past(o_mute)) & ~o_update) == '0
        && (o_update[0] || $stable(o_atten_half_db[7:0]))) else $error("setting moved");
    a_update_close: assert property (o_update != '0 |-> $past(o_busy) && !o_busy)
        else $error("update outside frame close");
    a_miss_flag: assert property ($fell(o_busy) |-> o_addr_miss == (o_update == '0))
        else $error("miss flag disagrees with update");
    a_chain_idle: assert property ($changed(o_chain_data) |-> o_busy)
        else $error("chain output moved while idle");

    // Main scenarios reached
    c_update_a: cover property (o_update[0]);
    c_update_b: cover property (o_update[1]);
    c_miss: cover property (o_addr_miss);
    c_setup: cover property (o_setup_violation);
endmodule // serial_attenuator_control_chk

bind serial_attenuator_control serial_attenuator_control_chk #(
    .CHANNELS(CHANNELS), .COUNT_W(COUNT_W)
) serial_attenuator_control_chk_inst (
    .i_clk, .i_sys_rst, .i_serial_clk, .i_load_shift_n, .i_serial_data, .o_chain_data,
    .o_mute, .o_atten_half_db, .o_update, .o_frame_addr, .o_frame_code, .o_bit_count,
    .o_short_frame, .o_addr_miss, .o_setup_violation, .o_busy
);

// ### tb/tb.sv
// Self-checking bench for the serial attenuator control
`timescale 1ns/100ps

module tb;
    logic        i_clk, i_sys_rst, sclk, load_n, sdata, chain, short_f, miss, setup_v, busy;
    logic [1:0]  mute, update;
    logic [15:0] atten;
    logic [7:0]  f_addr, f_code, bit_count;
    logic [31:0] seen;
    logic [8:0]  exp_b;
    logic [7:0]  codes [9] = '{8'h00, 8'h01, 8'h5f, 8'h60, 8'h61, 8'h7e, 8'h7f, 8'h80, 8'hff};
    int          error_cnt, n_compared;

    // ==========================================================================
    // Clock, instances
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    serial_attenuator_control serial_attenuator_control_inst (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_serial_clk(sclk), .i_load_shift_n(load_n),
        .i_serial_data(sdata), .o_chain_data(chain), .o_mute(mute), .o_atten_half_db(atten),
        .o_update(update), .o_frame_addr(f_addr), .o_frame_code(f_code),
        .o_bit_count(bit_count), .o_short_frame(short_f), .o_addr_miss(miss),
        .o_setup_violation(setup_v), .o_busy(busy)
    );

    host_link_model host_link_model_inst (
        .i_clk(i_clk), .i_chain_data(chain), .o_serial_clk(sclk),
        .o_load_shift_n(load_n), .o_serial_data(sdata)
    );

    // ==========================================================================
    // Helpers
    function automatic logic [8:0] exp_set(input logic [7:0] c);
        if (c <= 8'h5f) return {1'b0, c};
        if (c <= 8'h7e) return {1'b0, 8'((c << 1) - 8'h60)};
        return {1'b1, 8'h00}; // Muted channel reads zero
    endfunction

    task automatic check(input string name, input logic [31:0] seen_v, exp_v);
        n_compared++;
        if (seen_v !== exp_v) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp_v, seen_v);
        end
    endtask

    task automatic stop_test;
        $display("errors %0d compares %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Sixteen frames of roughly 160 cycles; generous bound
    initial begin
        repeat (20000) @(posedge i_clk);
        error_cnt++;
        stop_test();
    end

    // ==========================================================================
    // Main sequence
    initial begin
        i_sys_rst = 1'b1;
        error_cnt = 0;
        n_compared = 0;
        repeat (8) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
        check("reset_state", {mute, atten}, {2'b11, 16'h0000});
        // Code table on channel A, channel B parked at a level
        host_link_model_inst.send(32'h0144, 16, 6, seen);
        exp_b = exp_set(8'h44);
        foreach (codes[i]) begin
            host_link_model_inst.send({8'h00, codes[i]}, 16, 6, seen);
            check("chan_a", {mute[0], atten[7:0]}, exp_set(codes[i]));
            check("chan_b", {mute[1], atten[15:8]}, exp_b);
            check("bit_count", bit_count, 8'h10);
        end
        // Idle edges must leave the register, so old frame leaves intact
        host_link_model_inst.idle_pulses(4);
        host_link_model_inst.send(32'h0133, 16, 6, seen);
        check("chain_out", seen, 32'h00ff);
        // Two-device chain: near frame is the newest 16 bits
        host_link_model_inst.send(32'h0105_0030, 32, 6, seen);
        check("chain_pass", seen, 32'h0133_0105);
        check("chain_a", {mute[0], atten[7:0]}, exp_set(8'h30));
        check("chain_b", {mute[1], atten[15:8]}, exp_set(8'h33));
        check("chain_count", bit_count, 8'h20);
        check("chain_frame", {f_addr, f_code}, 16'h0030);
        // Unknown channel changes nothing
        host_link_model_inst.send(32'h0200, 16, 6, seen);
        check("miss", {miss, mute, atten}, {1'b1, 2'b00, 16'h3330});
        // Enable too close to the first clock rise
        host_link_model_inst.send(32'h017f, 16, 0, seen);
        check("setup_flag", setup_v, 1'b1);
        host_link_model_inst.send(32'h017f, 16, 6, seen);
        check("mute_b", {setup_v, mute[1], busy}, 3'b010);
        host_link_model_inst.send(32'h0fff, 12, 6, seen);
        check("short_flag", short_f, 1'b1);
        // Reset in mid-run; held four edges so no assertion sees a half-reset state
        i_sys_rst <= 1'b1;
        repeat (4) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
        check("rst_again", {mute, atten, short_f, miss}, {2'b11, 16'h0000, 2'b00});
        stop_test();
    end
endmodule // tb
